// *** common/ipp_pkg.sv ***
package ipp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SLOTS = 8;
    localparam int AI_MAX_BYTES = 8;
    localparam int IN_BYTES = 16;
    localparam int OUT_BYTES = 16;
    localparam int IN_WORDS = IN_BYTES / 4;
    localparam int OUT_WORDS = OUT_BYTES / 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_OBJ_SEL = 12'h000;
    localparam logic [11:0] OFF_OBJ_DATA = 12'h004;
    localparam logic [11:0] OFF_LAYOUT = 12'h008;
    localparam logic [11:0] OFF_SLOT_CFG = 12'h00C;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
    localparam logic [11:0] OFF_IMG_LEN = 12'h018;

    // ------------------------------------------------------------
    // Object indexes
    // ------------------------------------------------------------
    localparam logic [15:0] OBJ_IN_IMAGE = 16'h5000;
    localparam logic [15:0] OBJ_OUT_IMAGE = 16'h5001;
    localparam logic [15:0] OBJ_DIG_IN = 16'h6000;
    localparam logic [15:0] OBJ_DIG_IN_ALT = 16'h2000;
    localparam logic [15:0] OBJ_DIG_OUT = 16'h6200;
    localparam logic [15:0] OBJ_DIG_OUT_ALT = 16'h2100;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_OBJ_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_SLOT_CFG = 32'h0000_0000;
    localparam logic [3:0] RST_AI_BYTES = 4'h0;
    localparam logic [4:0] RST_AO_BYTES = 5'h00;
    localparam logic [4:0] RST_DO_BYTES = 5'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [127:0] RST_OUT_IMAGE = 128'h0;

    // ------------------------------------------------------------
    // Interrupt bit positions
    // ------------------------------------------------------------
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_OUT_WR = 1;
    localparam int IRQ_OBJ_ERR = 2;
    localparam int IRQ_BITS = 3;

    // ------------------------------------------------------------
    // Module kinds per slot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        KIND_NONE = 4'h0,
        KIND_DI1_DIAG = 4'h1,
        KIND_DI2 = 4'h2,
        KIND_DI2_DIAG = 4'h3,
        KIND_DI4 = 4'h4,
        KIND_DI8 = 4'h5
    } ipp_kind_t;

    typedef struct packed {
        logic [7:0] bits;
        logic [3:0] width;
    } ipp_field_t;

    typedef struct packed {
        logic [4:0] do_bytes;
        logic [4:0] ao_bytes;
        logic [3:0] ai_bytes;
    } ipp_layout_t;

endpackage

// *** design/ipp_slot_field.sv ***
`timescale 1ns/1ps
module ipp_slot_field
(
    // Slot configuration
    input wire logic [3:0] kind,
    // Channel signals
    input wire logic [7:0] chan_state,
    input wire logic [7:0] chan_fault,
    // Packed field
    output ipp_pkg::ipp_field_t field
);

    always_comb
    begin
        field.bits = 8'h00;
        field.width = 4'h0;
        unique case (kind)
            ipp_pkg::KIND_DI1_DIAG:
            begin
                field.bits = {6'h00, chan_fault[0], chan_state[0]};
                field.width = 4'h2;
            end
            ipp_pkg::KIND_DI2:
            begin
                field.bits = {6'h00, chan_state[1:0]};
                field.width = 4'h2;
            end
            ipp_pkg::KIND_DI2_DIAG:
            begin
                field.bits = {4'h0, chan_fault[1:0], chan_state[1:0]};
                field.width = 4'h4;
            end
            ipp_pkg::KIND_DI4:
            begin
                field.bits = {4'h0, chan_state[3:0]};
                field.width = 4'h4;
            end
            ipp_pkg::KIND_DI8:
            begin
                field.bits = chan_state;
                field.width = 4'h8;
            end
            default:
            begin
                field.bits = 8'h00;
                field.width = 4'h0;
            end
        endcase
    end

endmodule

// *** design/ipp_packer.sv ***
`timescale 1ns/1ps
module ipp_packer
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Field side inputs
    input wire logic [ipp_pkg::SLOTS*8-1:0] chan_state,
    input wire logic [ipp_pkg::SLOTS*8-1:0] chan_fault,
    input wire logic [ipp_pkg::AI_MAX_BYTES*8-1:0] ai_data,
    // Field side outputs
    output logic [ipp_pkg::OUT_BYTES*8-1:0] out_image,
    output logic irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] obj_sel_r;
    logic [31:0] slot_cfg_r;
    ipp_pkg::ipp_layout_t layout_r;
    logic [ipp_pkg::IRQ_BITS-1:0] irq_stat_r;
    logic [ipp_pkg::IRQ_BITS-1:0] irq_mask_r;
    logic [ipp_pkg::IN_BYTES*8-1:0] in_img_r;
    logic [ipp_pkg::SLOTS*8-1:0] fault_prev_r;
    logic [31:0] prdata_nxt;
    logic pslverr_nxt;

    logic [15:0] obj_index;
    logic [7:0] obj_sub;
    assign obj_index = obj_sel_r[15:0];
    assign obj_sub = obj_sel_r[23:16];

    // ------------------------------------------------------------
    // Per-slot fields
    // ------------------------------------------------------------
    ipp_pkg::ipp_field_t field [ipp_pkg::SLOTS];

    genvar gs;
    generate
        for (gs = 0; gs < ipp_pkg::SLOTS; gs++)
        begin : g_slot
            ipp_slot_field u_field
            (
                .kind(slot_cfg_r[gs*4 +: 4]),
                .chan_state(chan_state[gs*8 +: 8]),
                .chan_fault(chan_fault[gs*8 +: 8]),
                .field(field[gs])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Bit packing
    // ------------------------------------------------------------
    logic [ipp_pkg::SLOTS*8-1:0] dig_bits;
    logic [6:0] dig_len;
    logic [3:0] di_bytes;
    logic [ipp_pkg::IN_BYTES*8-1:0] in_img_c;
    logic [6:0] ai_shift;

    always_comb
    begin
        dig_bits = '0;
        dig_len = 7'h00;
        for (int s = 0; s < ipp_pkg::SLOTS; s++)
        begin
            // Contiguous, slot order, no word alignment
            dig_bits = dig_bits
                | (64'(field[s].bits) << dig_len);
            dig_len = dig_len + 7'(field[s].width);
        end
    end

    assign di_bytes = 4'((dig_len + 7'h07) >> 3);
    assign ai_shift = {layout_r.ai_bytes, 3'b000};

    always_comb
    begin
        // Analog bytes first, digital bytes right after
        in_img_c = (128'(dig_bits) << ai_shift)
            | (128'(ai_data) & ~({128{1'b1}} << ai_shift));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_img_r <= '0;
        else
            in_img_r <= in_img_c;
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic setup;
    logic wr_en;
    logic [4:0] do_pos;
    logic [4:0] di_pos;
    logic is_in_img;
    logic is_out_img;
    logic is_dig_in;
    logic is_dig_out;
    logic sub_word_ok;
    logic do_sub_ok;
    logic di_sub_ok;
    logic obj_err;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;

    assign is_in_img = (obj_index == ipp_pkg::OBJ_IN_IMAGE);
    assign is_out_img = (obj_index == ipp_pkg::OBJ_OUT_IMAGE);
    assign is_dig_in = (obj_index == ipp_pkg::OBJ_DIG_IN)
        || (obj_index == ipp_pkg::OBJ_DIG_IN_ALT);
    assign is_dig_out = (obj_index == ipp_pkg::OBJ_DIG_OUT)
        || (obj_index == ipp_pkg::OBJ_DIG_OUT_ALT);
    assign sub_word_ok = (obj_sub < 8'(ipp_pkg::IN_WORDS));
    assign di_sub_ok = (obj_sub != 8'h00) && (obj_sub <= 8'(di_bytes));
    assign do_sub_ok = (obj_sub != 8'h00)
        && (obj_sub <= 8'(layout_r.do_bytes))
        && (do_pos < 5'(ipp_pkg::OUT_BYTES));
    assign di_pos = 5'(layout_r.ai_bytes) + obj_sub[4:0] - 5'h01;
    assign do_pos = layout_r.ao_bytes + obj_sub[4:0] - 5'h01;

    // Object data access validity
    always_comb
    begin
        obj_err = 1'b1;
        if (is_in_img)
            obj_err = pwrite | ~sub_word_ok;
        else if (is_out_img)
            obj_err = ~sub_word_ok;
        else if (is_dig_in)
            obj_err = pwrite | ((obj_sub != 8'h00) & ~di_sub_ok);
        else if (is_dig_out)
            obj_err = (obj_sub != 8'h00) & ~do_sub_ok;
    end

    // Read mux and error answer
    always_comb
    begin
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        unique case (paddr)
            ipp_pkg::OFF_OBJ_SEL:
                prdata_nxt = {8'h00, obj_sel_r[23:0]};
            ipp_pkg::OFF_OBJ_DATA:
            begin
                pslverr_nxt = obj_err;
                if (obj_err)
                    prdata_nxt = 32'h0000_0000;
                else if (is_in_img)
                    prdata_nxt = in_img_r[{obj_sub[1:0], 5'h00} +: 32];
                else if (is_out_img)
                    prdata_nxt = out_image[{obj_sub[1:0], 5'h00} +: 32];
                else if (is_dig_in && obj_sub == 8'h00)
                    prdata_nxt = {28'h000_0000, di_bytes};
                else if (is_dig_in)
                    prdata_nxt = {24'h00_0000,
                        in_img_r[{di_pos[3:0], 3'b000} +: 8]};
                else if (obj_sub == 8'h00)
                    prdata_nxt = {27'h000_0000, layout_r.do_bytes};
                else
                    prdata_nxt = {24'h00_0000,
                        out_image[{do_pos[3:0], 3'b000} +: 8]};
            end
            ipp_pkg::OFF_LAYOUT:
                prdata_nxt = {11'h000, layout_r.do_bytes, 3'h0,
                    layout_r.ao_bytes, 4'h0, layout_r.ai_bytes};
            ipp_pkg::OFF_SLOT_CFG:
                prdata_nxt = slot_cfg_r;
            ipp_pkg::OFF_IRQ_STAT:
                prdata_nxt = {29'h0000_0000, irq_stat_r};
            ipp_pkg::OFF_IRQ_MASK:
                prdata_nxt = {29'h0000_0000, irq_mask_r};
            ipp_pkg::OFF_IMG_LEN:
                prdata_nxt = {16'h0000, 4'h0, di_bytes, 4'h0,
                    4'(layout_r.ai_bytes + di_bytes)};
            default:
                pslverr_nxt = 1'b1;
        endcase
    end

    // One wait-free access phase per transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            if (setup)
            begin
                pslverr <= pslverr_nxt;
                prdata <= pwrite ? 32'h0000_0000 : prdata_nxt;
            end
            else
            begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [3:0] ai_wr;
    assign ai_wr = (pwdata[3:0] > 4'(ipp_pkg::AI_MAX_BYTES))
        ? 4'(ipp_pkg::AI_MAX_BYTES) : pwdata[3:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            obj_sel_r <= ipp_pkg::RST_OBJ_SEL;
            slot_cfg_r <= ipp_pkg::RST_SLOT_CFG;
            layout_r.ai_bytes <= ipp_pkg::RST_AI_BYTES;
            layout_r.ao_bytes <= ipp_pkg::RST_AO_BYTES;
            layout_r.do_bytes <= ipp_pkg::RST_DO_BYTES;
            irq_mask_r <= ipp_pkg::RST_IRQ;
        end
        else if (wr_en && !pslverr)
        begin
            unique case (paddr)
                ipp_pkg::OFF_OBJ_SEL:
                    obj_sel_r <= {8'h00, pwdata[23:0]};
                ipp_pkg::OFF_LAYOUT:
                begin
                    layout_r.ai_bytes <= ai_wr;
                    layout_r.ao_bytes <= pwdata[12:8];
                    layout_r.do_bytes <= pwdata[20:16];
                end
                ipp_pkg::OFF_SLOT_CFG:
                    slot_cfg_r <= pwdata;
                ipp_pkg::OFF_IRQ_MASK:
                    irq_mask_r <= pwdata[ipp_pkg::IRQ_BITS-1:0];
                default:
                    obj_sel_r <= obj_sel_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output image
    // ------------------------------------------------------------
    logic obj_wr;
    logic out_wr;
    assign obj_wr = wr_en && (paddr == ipp_pkg::OFF_OBJ_DATA);
    assign out_wr = obj_wr && !pslverr && (is_out_img
        || (is_dig_out && obj_sub != 8'h00));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_image <= ipp_pkg::RST_OUT_IMAGE;
        else if (out_wr && is_out_img)
        begin
            for (int b = 0; b < 4; b++)
                if (pstrb[b])
                    out_image[{obj_sub[1:0], 5'h00} + 7'(b*8) +: 8]
                        <= pwdata[b*8 +: 8];
        end
        else if (out_wr && pstrb[0])
            out_image[{do_pos[3:0], 3'b000} +: 8] <= pwdata[7:0];
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [ipp_pkg::IRQ_BITS-1:0] irq_set;
    logic [ipp_pkg::IRQ_BITS-1:0] irq_clr;
    logic fault_arm_r;

    always_comb
    begin
        irq_set = '0;
        // First sample after reset only primes the edge detector
        irq_set[ipp_pkg::IRQ_FAULT] = fault_arm_r
            & |(chan_fault & ~fault_prev_r);
        irq_set[ipp_pkg::IRQ_OUT_WR] = out_wr;
        irq_set[ipp_pkg::IRQ_OBJ_ERR] = obj_wr & pslverr;
        irq_clr = '0;
        if (wr_en && paddr == ipp_pkg::OFF_IRQ_STAT)
            irq_clr = pwdata[ipp_pkg::IRQ_BITS-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_prev_r <= '0;
            fault_arm_r <= 1'b0;
            irq_stat_r <= ipp_pkg::RST_IRQ;
            irq <= 1'b0;
        end
        else
        begin
            fault_prev_r <= chan_fault;
            fault_arm_r <= 1'b1;
            // Set beats clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
        end
    end

endmodule

// *** verif/ipp_monitor.sv ***
`timescale 1ns/1ps
module ipp_monitor
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Field side
    input wire logic [63:0] chan_state,
    input wire logic [63:0] chan_fault,
    input wire logic [63:0] ai_data,
    input wire logic [127:0] out_image,
    input wire logic irq
);
    logic [63:0] flt_q;
    logic [2:0] since_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // --------------------------------
    // Cycles since a write or new fault
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flt_q <= '0;
        else
            flt_q <= chan_fault;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_r <= 3'h7;
        else if ((psel && penable && pwrite) || |(chan_fault & ~flt_q))
            since_r <= 3'h0;
        else if (since_r != 3'h7)
            since_r <= since_r + 3'h1;
    end

    // --------------------------------
    // Properties
    // --------------------------------
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    handshake_a: assert property (setup_s ##1 access_s |-> pready ##1 !pready)
        else $error("ready not one cycle in access");
    idle_ready_a: assert property (!(psel && penable) |-> !pready)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!(psel && penable && !pwrite) |->
        prdata == 32'h0000_0000) else $error("read data not zero");
    unmapped_err_a: assert property ((psel && penable && paddr > 12'h018)
        |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped ok");
    out_hold_a: assert property ($changed(out_image) |->
        $past(psel && penable && pwrite)) else $error("output image drift");
    irq_cause_a: assert property ($rose(irq) |-> since_r < 3'h4)
        else $error("irq without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(pwrite, 1) ||
        $past(pwrite, 2) || $past(pwrite, 3)) else $error("irq fell alone");
endmodule

bind ipp_packer ipp_monitor ipp_monitor_inst
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_state(chan_state), .chan_fault(chan_fault), .ai_data(ai_data),
    .out_image(out_image), .irq(irq)
);

// *** verif/ipp_field_model.sv ***
`timescale 1ns/1ps
module ipp_field_model
(
    // Clock and node layout
    input wire logic pclk,
    input wire logic [31:0] kinds,
    // Intended channel levels
    input wire logic [63:0] st,
    input wire logic [63:0] ft,
    // Channel lines
    output logic [63:0] chan_state,
    output logic [63:0] chan_fault
);
    logic tog_r = 1'b0;
    logic [7:0] sm;
    logic [7:0] fm;

    always_ff @(posedge pclk)
        tog_r <= ~tog_r;

    // Absent channels toggle, absent fault lines sit high
    always_comb
    begin
        for (int s = 0; s < 8; s++)
        begin
            case (kinds[s*4+:4])
                4'h1: {sm, fm} = 16'h0101;
                4'h2: {sm, fm} = 16'h0300;
                4'h3: {sm, fm} = 16'h0303;
                4'h4: {sm, fm} = 16'h0F00;
                4'h5: {sm, fm} = 16'hFF00;
                default: {sm, fm} = 16'h0000;
            endcase
            chan_state[s*8+:8] = (st[s*8+:8] & sm) | (~sm & {8{tog_r}});
            chan_fault[s*8+:8] = (ft[s*8+:8] & fm) | ~fm;
        end
    end
endmodule

// *** verif/process_image_packer_tb.sv ***
`timescale 1ns/1ps
module process_image_packer_tb;
    localparam logic [31:0] KINDS = 32'h0005_4321;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] chan_state, chan_fault, ai_data, st, ft;
    logic [127:0] out_image;
    int err_total, samples_checked;

    ipp_packer ipp_packer_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_state(chan_state), .chan_fault(chan_fault),
        .ai_data(ai_data), .out_image(out_image), .irq(irq));
    ipp_field_model ipp_field_model_inst (.pclk(pclk), .kinds(KINDS),
        .st(st), .ft(ft), .chan_state(chan_state), .chan_fault(chan_fault));

    // --------------------------------
    // Helpers
    // --------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20)
            err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task obj(input logic w, input logic [15:0] idx, input logic [7:0] sub,
             input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, ipp_pkg::OFF_OBJ_SEL, {8'h00, sub, idx}, 4'hF);
        apb(w, ipp_pkg::OFF_OBJ_DATA, d, s);
    endtask

    function automatic logic [127:0] exp_img(input logic [3:0] nai,
        input logic [63:0] s, input logic [63:0] f, output int nd);
        int ns [6] = '{0, 1, 2, 2, 4, 8};
        int nf [6] = '{0, 1, 0, 2, 0, 0};
        logic [127:0] m;
        int p;
        int k;
        m = '0;
        for (int b = 0; b < nai; b++)
            m[b*8+:8] = ai_data[b*8+:8];
        p = nai * 8;
        for (int sl = 0; sl < 8; sl++)
        begin
            k = KINDS[sl*4+:4];
            for (int c = 0; c < ns[k]; c++)
                m[p+c] = s[sl*8+c];
            p += ns[k];
            for (int c = 0; c < nf[k]; c++)
                m[p+c] = f[sl*8+c];
            p += nf[k];
        end
        nd = (p - nai * 8 + 7) / 8;
        return m;
    endfunction

    // --------------------------------
    // Scenarios
    // --------------------------------
    task t_regs;
        for (int a = 0; a < 8; a++)
        begin
            apb(1'b0, 12'(a * 4), 32'h0000_0000, 4'h0);
            check(rd, 32'h0000_0000);
            check({31'h0, er}, {31'h0, a == 1 || a == 7});
        end
    endtask

    task t_pack(input logic [3:0] nai, input logic [63:0] s,
                input logic [63:0] f);
        logic [127:0] img;
        int nd;
        st <= s;
        ft <= f;
        apb(1'b1, ipp_pkg::OFF_SLOT_CFG, KINDS, 4'hF);
        apb(1'b1, ipp_pkg::OFF_LAYOUT, {28'h0, nai}, 4'hF);
        img = exp_img(nai, s, f, nd);
        for (int w = 0; w < 4; w++)
        begin
            obj(1'b0, ipp_pkg::OBJ_IN_IMAGE, 8'(w), 32'h0, 4'h0);
            check(rd, img[w*32+:32]);
        end
        for (int n = 0; n <= nd + 1; n++)
        begin
            obj(1'b0, ipp_pkg::OBJ_DIG_IN, 8'(n), 32'h0, 4'h0);
            check({31'h0, er}, {31'h0, n > nd});
            if (n <= nd)
                check(rd, n == 0 ? 32'(nd) : {24'h0, img[(nai+n-1)*8+:8]});
            obj(1'b0, ipp_pkg::OBJ_DIG_IN_ALT, 8'(n), 32'h0, 4'h0);
            check({31'h0, er}, {31'h0, n > nd});
            if (n <= nd)
                check(rd, n == 0 ? 32'(nd) : {24'h0, img[(nai+n-1)*8+:8]});
        end
        apb(1'b0, ipp_pkg::OFF_IMG_LEN, 32'h0, 4'h0);
        check(rd, {20'h0, 4'(nd), 4'h0, 4'(nai + nd)});
    endtask

    task t_out;
        apb(1'b1, ipp_pkg::OFF_IRQ_STAT, 32'h0000_0007, 4'hF);
        apb(1'b1, ipp_pkg::OFF_LAYOUT, 32'h0002_0203, 4'hF);
        obj(1'b1, ipp_pkg::OBJ_OUT_IMAGE, 8'h01, 32'hDDCC_BBAA, 4'hA);
        @(posedge pclk);
        check(out_image[63:32], 32'hDD00_BB00);
        check(out_image[31:0], 32'h0000_0000);
        obj(1'b1, ipp_pkg::OBJ_DIG_OUT, 8'h01, 32'h0000_00A5, 4'h1);
        obj(1'b1, ipp_pkg::OBJ_DIG_OUT_ALT, 8'h02, 32'h0000_005A, 4'h1);
        @(posedge pclk);
        check(out_image[31:0], 32'h5AA5_0000);
        obj(1'b1, ipp_pkg::OBJ_DIG_OUT, 8'h03, 32'h0000_00FF, 4'h1);
        check({31'h0, er}, 32'h0000_0001);
        obj(1'b0, ipp_pkg::OBJ_DIG_OUT_ALT, 8'h00, 32'h0, 4'h0);
        check(rd, 32'h0000_0002);
        obj(1'b0, ipp_pkg::OBJ_OUT_IMAGE, 8'h01, 32'h0, 4'h0);
        check(rd, 32'hDD00_BB00);
        obj(1'b0, ipp_pkg::OBJ_DIG_OUT, 8'h01, 32'h0, 4'h0);
        check(rd, 32'h0000_00A5);
        apb(1'b0, ipp_pkg::OFF_IRQ_STAT, 32'h0, 4'h0);
        check(rd, 32'h0000_0006);
    endtask

    task t_irq;
        int n;
        apb(1'b1, ipp_pkg::OFF_IRQ_MASK, 32'h0000_0007, 4'hF);
        apb(1'b1, ipp_pkg::OFF_IRQ_STAT, 32'h0000_0007, 4'hF);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        ft <= 64'h0000_0000_0001_0001;
        n = 0;
        while (irq !== 1'b1 && n < 10)
        begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, ipp_pkg::OFF_IRQ_STAT, 32'h0, 4'h0);
        check(rd, 32'h0000_0001);
        apb(1'b1, ipp_pkg::OFF_IRQ_STAT, 32'h0000_0001, 4'hF);
        apb(1'b1, ipp_pkg::OFF_IRQ_MASK, 32'h0000_0003, 4'hF);
        obj(1'b1, ipp_pkg::OBJ_IN_IMAGE, 8'h00, 32'h1234_5678, 4'hF);
        check({31'h0, er}, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b0, ipp_pkg::OFF_IRQ_STAT, 32'h0, 4'h0);
        check(rd, 32'h0000_0004);
    endtask

    // --------------------------------
    // Run
    // --------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        wrap_up;
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        st = 64'h0;
        ft = 64'h0;
        ai_data = 64'h8877_6655_4433_2211;
        err_total = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_pack(4'h0, 64'h00FF_F5A6_E97E_0302, 64'h0000_0000_0003_0001);
        t_pack(4'h3, 64'h0000_0A59_1681_FCFD, 64'h0000_0000_0001_0000);
        t_out;
        t_irq;
        wrap_up;
    end
endmodule
